/* File: rtl/adc_conversion_sequencer.sv */
// APB-controlled sequencer for a 10-bit successive-approximation converter.
// Assumes an analog front end with a comparator answering the trial word
// combinationally, and port pins synchronous to core_clk.
//
// Functional notes
// - Result register pair has no reset; undefined until converted or written.
// - Completion shows as start bit cleared or as the interrupt.
// - At least two bit periods pass after a conversion before acquiring.
// - One conversion takes exactly twelve conversion-bit periods.
// - Clock select picks 2,4,8,16,32,64 oscillator periods or RC.
// - RC source gives a nominal four microsecond bit period.
// - Hold capacitor disconnects from the pin when conversion starts.
// - Channel select and pin directions never block a started conversion.
// - Port data reads zero on every analog-configured pin.
// - Digitally configured pins are still converted when selected.
// - Completion loads result, clears start bit, sets done flag.
// - Clearing start aborts, keeps result, reacquires after two periods.
// - Justify bit selects right or left alignment with zero padding.
// - Reset returns control registers, powers off, aborts conversion.
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module adc_conversion_sequencer
  import adc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog front end
  output afe_t afe,
  input wire logic comp_above,
  // Port pins and completion request
  input wire logic [7:0] port_pins,
  output logic conv_irq
);

  ctrl0_t c0_r;
  ctrl1_t c1_r;
  ctrl0_t wr0;
  logic [RES_W-1:0] res_r;
  logic flag_r;
  logic ie_r;
  seq_state_t state_r;
  seq_state_t state_nxt;
  logic [3:0] tad_cnt_r;
  logic [11:0] cyc_r;
  afe_t afe_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic irq_r;
  logic [31:0] rd_val;
  logic rd_hit;
  logic wr_en;
  logic tick;
  logic restart;
  logic start_conv;
  logic abort;
  logic done_set;
  logic gap_end;
  logic [2:0] clk_sel;
  logic [RES_W-1:0] bit_cur;

  // ==========================================================
  // Decode
  assign wr_en = psel && penable && pwrite && pready_r;
  assign wr0 = ctrl0_t'(pwdata[7:0]);
  assign clk_sel = {c1_r.clk_hi, c0_r.clk_lo};
  // Start needs only the acquire state and the start bit; channel and pins are not looked at
  assign start_conv = (state_r == S_ACQ) && c0_r.go;
  assign abort = (state_r == S_CONV) && wr_en && (paddr == OFS_CTRL0)
    && !wr0.go;
  assign done_set = (state_r == S_CONV) && tick
    && (tad_cnt_r == 4'(CONV_TADS - 1));
  assign gap_end = (state_r == S_GAP) && tick
    && (tad_cnt_r == 4'(GAP_TADS - 1));
  // Divider is held while idle and cleared on every change that comes
  // without a tick. Built from registered state and the APB abort write: state_nxt depends on
  // tick, so using it here would close a combinational loop.
  assign restart = (state_r == S_OFF) || (state_r == S_ACQ) || abort
    || !c0_r.converter_power_on;
  assign bit_cur = SAR_TOP >> (tad_cnt_r - 4'h1);

  conv_clock_divider #(
    .CNT_W(DIV_W)
  ) u_div (
    .core_clk(core_clk),
    .rst(rst),
    .restart(restart),
    .sel(clk_sel),
    .tick(tick)
  );

  // ==========================================================
  // Sequence state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      S_OFF: begin
        if (c0_r.converter_power_on) state_nxt = S_ACQ;
      end
      S_ACQ: begin
        if (!c0_r.converter_power_on) state_nxt = S_OFF;
        else if (start_conv) state_nxt = S_CONV;
      end
      S_CONV: begin
        if (!c0_r.converter_power_on) state_nxt = S_OFF;
        else if (abort || done_set) state_nxt = S_GAP;
      end
      S_GAP: begin
        if (!c0_r.converter_power_on) state_nxt = S_OFF;
        else if (gap_end) state_nxt = S_ACQ;
      end
    endcase
  end

  // Reset lands in the off state, ending any conversion
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r <= S_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Bit-period counter within a state, and a cycle count for checks
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tad_cnt_r <= 4'h0;
      cyc_r <= 12'h000;
    end else if (state_nxt != state_r) begin
      tad_cnt_r <= 4'h0;
      cyc_r <= 12'h001;
    end else begin
      if (tick) tad_cnt_r <= tad_cnt_r + 4'h1;
      if (cyc_r != 12'hFFF) cyc_r <= cyc_r + 12'h001;
    end
  end

  // ==========================================================
  // Control registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      c0_r <= ctrl0_t'(CTRL0_RST);
      c1_r <= ctrl1_t'(CTRL1_RST);
    end else begin
      if (wr_en && (paddr == OFS_CTRL0)) begin
        c0_r <= wr0;
        c0_r.rsv <= 1'b0;
        // Start bit only holds while powered
        c0_r.go <= wr0.go && wr0.converter_power_on;
      end
      // Hardware clear beats a same-cycle software write
      if (done_set) c0_r.go <= 1'b0;
      if (wr_en && (paddr == OFS_CTRL1)) begin
        c1_r <= ctrl1_t'(pwdata[7:0]);
        c1_r.rsv <= 2'h0;
      end
    end
  end

  // Done flag: set wins over write-one-to-clear
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flag_r <= 1'b0;
      ie_r <= 1'b0;
    end else begin
      if (done_set) begin
        flag_r <= 1'b1;
      end else if (wr_en && (paddr == OFS_STATUS) && pwdata[0]) begin
        flag_r <= 1'b0;
      end
      if (wr_en && (paddr == OFS_STATUS)) ie_r <= pwdata[1];
    end
  end

  // ==========================================================
  // Result pair: no reset, written by completion or by software
  always_ff @(posedge core_clk) begin
    if (done_set) begin
      res_r <= afe_r.trial;
    end else if (wr_en && (paddr == OFS_RES_HI)) begin
      if (c1_r.result_justify) res_r[9:8] <= pwdata[1:0];
      else res_r[9:2] <= pwdata[7:0];
    end else if (wr_en && (paddr == OFS_RES_LO)) begin
      if (c1_r.result_justify) res_r[7:0] <= pwdata[7:0];
      else res_r[1:0] <= pwdata[7:6];
    end
  end

  // ==========================================================
  // Front end: hold switch, channel, trial word
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      afe_r <= '0;
    end else begin
      // Switch opens at the start edge so the held sample is converted
      afe_r.hold_connect <= (state_nxt == S_ACQ);
      afe_r.channel <= c0_r.channel_select;
      afe_r.powered <= c0_r.converter_power_on;
      if (start_conv) begin
        afe_r.trial <= SAR_TOP;
      end else if ((state_r == S_CONV) && tick && (tad_cnt_r != 4'h0)
          && (tad_cnt_r <= 4'(RES_W))) begin
        // Period 0 settles; periods 1..10 resolve one bit each
        afe_r.trial <= (comp_above ? afe_r.trial : (afe_r.trial & ~bit_cur))
          | (bit_cur >> 1);
      end
    end
  end

  // ==========================================================
  // APB read data and answer
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      OFS_CTRL0: rd_val[7:0] = c0_r;
      OFS_CTRL1: rd_val[7:0] = c1_r;
      OFS_RES_HI: rd_val[7:0] = c1_r.result_justify ?
        {6'h00, res_r[9:8]} : res_r[9:2];
      OFS_RES_LO: rd_val[7:0] = c1_r.result_justify ?
        res_r[7:0] : {res_r[1:0], 6'h00};
      OFS_STATUS: rd_val[3:0] = {(state_r == S_ACQ), (state_r == S_CONV),
        ie_r, flag_r};
      OFS_PORT: rd_val[7:0] = port_pins & ~analog_mask(c1_r.port_cfg);
      default: rd_hit = 1'b0;
    endcase
  end

  // Answer is ready in the first access cycle; data caught at setup
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else if (psel && !penable) begin
      prdata_r <= pwrite ? 32'h0000_0000 : rd_val;
      pready_r <= 1'b1;
      pslverr_r <= !rd_hit || (pwrite && (paddr == OFS_PORT));
    end else begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  // Completion request toward the interrupt controller
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) irq_r <= 1'b0;
    else irq_r <= flag_r && ie_r;
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign afe = afe_r;
  assign conv_irq = irq_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_conv_twelve_tad: assert property (
    done_set |-> cyc_r == 12'(CONV_TADS * tad_cycles(clk_sel)))
    else $error("conversion did not last twelve bit periods");
  a_gap_two_tad: assert property (
    gap_end |-> cyc_r == 12'(GAP_TADS * tad_cycles(clk_sel)))
    else $error("gap before acquisition not two bit periods");
  a_done_effects: assert property (
    done_set |=> flag_r && !c0_r.go && (res_r == $past(afe_r.trial)))
    else $error("completion effects missing");
  a_abort_keeps: assert property (
    abort |=> (state_r == S_GAP) && (res_r == $past(res_r)) && !flag_r
      || $past(flag_r))
    else $error("abort changed result or skipped gap");
  a_hold_open: assert property (
    (state_r == S_CONV) |-> !afe_r.hold_connect)
    else $error("hold switch closed during conversion");
  a_start_any: assert property (
    start_conv && c0_r.converter_power_on |=> state_r == S_CONV)
    else $error("started conversion was blocked");
  a_port_mask: assert property (
    psel && !penable && !pwrite && (paddr == OFS_PORT) |=>
      (prdata_r[7:0] & analog_mask($past(c1_r.port_cfg))) == 8'h00)
    else $error("analog pin read as nonzero");
  a_justify_pad: assert property (
    psel && !penable && !pwrite && (paddr == OFS_RES_HI)
      && c1_r.result_justify |=> prdata_r[7:2] == 6'h00)
    else $error("right-justified high byte not padded");
  a_off_idle: assert property (
    !c0_r.converter_power_on |=> (state_r == S_OFF) && !c0_r.go
      || $past(state_r == S_OFF) && c0_r.converter_power_on)
    else $error("converter active while powered off");

endmodule // adc_conversion_sequencer

/* File: rtl/adc_pkg.sv */
// Shared constants, types and helpers for the converter sequencer.
// Assumes a 20 MHz core clock that also serves as the oscillator.
package adc_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned RC_TAD_NS = 4000;
  localparam int unsigned RC_TAD_CYC =
    (RC_TAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CONV_TADS = 12;
  localparam int unsigned GAP_TADS = 2;
  localparam int unsigned RES_W = 10;
  localparam int unsigned DIV_W = 7;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] OFS_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_CTRL1 = 8'h04;
  localparam logic [7:0] OFS_RES_HI = 8'h08;
  localparam logic [7:0] OFS_RES_LO = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_PORT = 8'h14;
  localparam logic [7:0] CTRL0_RST = 8'h00;
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [RES_W-1:0] SAR_TOP = 10'h200;

  // ==========================================================
  // Field layouts
  typedef struct packed {
    logic [1:0] clk_lo;
    logic [2:0] channel_select;
    logic go;
    logic rsv;
    logic converter_power_on;
  } ctrl0_t;

  typedef struct packed {
    logic result_justify;
    logic clk_hi;
    logic [1:0] rsv;
    logic [3:0] port_cfg;
  } ctrl1_t;

  typedef struct packed {
    logic hold_connect;
    logic [2:0] channel;
    logic [RES_W-1:0] trial;
    logic powered;
  } afe_t;

  typedef enum logic [3:0] {
    S_OFF = 4'b0001,
    S_ACQ = 4'b0010,
    S_CONV = 4'b0100,
    S_GAP = 4'b1000
  } seq_state_t;

  // ==========================================================
  // Oscillator periods per conversion-bit period
  function automatic logic [DIV_W-1:0] tad_cycles(input logic [2:0] sel);
    case (sel)
      3'h0: tad_cycles = 7'h02;
      3'h4: tad_cycles = 7'h04;
      3'h1: tad_cycles = 7'h08;
      3'h5: tad_cycles = 7'h10;
      3'h2: tad_cycles = 7'h20;
      3'h6: tad_cycles = 7'h40;
      default: tad_cycles = DIV_W'(RC_TAD_CYC);
    endcase
  endfunction

  // Pins that are not digital I/O (analog or reference); bit i is pin i
  function automatic logic [7:0] analog_mask(input logic [3:0] cfg);
    case (cfg)
      4'h0, 4'h1, 4'h8: analog_mask = 8'hFF;
      4'h2, 4'h3, 4'hC: analog_mask = 8'h1F;
      4'h4, 4'h5, 4'hD: analog_mask = 8'h0F;
      4'h9, 4'hA, 4'hB: analog_mask = 8'h3F;
      4'hE: analog_mask = 8'h01;
      4'hF: analog_mask = 8'h0D;
      default: analog_mask = 8'h00;
    endcase
  endfunction

endpackage

/* File: rtl/conv_clock_divider.sv */
// Conversion-bit period generator: one-cycle tick per period.
// Assumes the select stays stable while a conversion runs.
`timescale 1ns/1ps
module conv_clock_divider
  import adc_pkg::*;
#(
  parameter int unsigned CNT_W = DIV_W
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Control
  input wire logic restart,
  input wire logic [2:0] sel,
  // Period tick
  output logic tick
);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] limit;

  // Divider from the oscillator, RC path is a longer fixed count
  assign limit = CNT_W'(tad_cycles(sel) - 7'h01);
  // Compare with >= so a select change cannot run the count away
  assign tick = !restart && (cnt_r >= limit);

  // ==========================================================
  // Period counter
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (restart || tick) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

endmodule // conv_clock_divider

/* File: test/afe_model.sv */
// Analog front end model: one level per channel, ideal comparator.
// Assumes the sequencer drives afe from core_clk registers.
`timescale 1ns/1ps
module afe_model
  import adc_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Sequencer side and pin levels
  input wire afe_t afe,
  input wire logic [7:0][9:0] lvl,
  output logic comp_above
);
  logic [9:0] held;
  // Follow the pin only while the sample switch is closed
  always @(posedge core_clk) begin
    if (afe.hold_connect)
      held <= lvl[afe.channel];
  end
  // Live pin changes must not reach the comparator once held
  assign comp_above = held >= afe.trial;
endmodule // afe_model

/* File: test/tb_top.sv */
// Self-checking bench for the converter sequencer over APB.
// Assumes afe_model as partner and the zero-wait APB slave.
`timescale 1ns/1ps
module tb_top
  import adc_pkg::*;
;
  typedef struct packed {
    logic err;
    logic [31:0] mask;
    logic [31:0] data;
  } exp_t;
  logic core_clk = 0;
  logic rst = 1;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic comp_above;
  logic conv_irq;
  afe_t afe;
  logic [7:0] port_pins = '0;
  logic [7:0][9:0] lvl = '0;
  logic [9:0] res_a;
  logic seen = 0;
  exp_t expq[$];
  int spanq[$];
  int cnt = 0;
  int seed = 74191;
  int error_cnt = 0;
  int num_checks = 0;
  // Acquisition wait of 13 us: settling, charging and a warm-die term
  localparam int ACQ_WAIT_CYC = 260;

  always #25 core_clk = ~core_clk;

  adc_conversion_sequencer u_adc_conversion_sequencer (
    .core_clk(core_clk),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .afe(afe),
    .comp_above(comp_above),
    .port_pins(port_pins),
    .conv_irq(conv_irq)
  );
  afe_model u_afe_model (
    .core_clk(core_clk),
    .afe(afe),
    .lvl(lvl),
    .comp_above(comp_above)
  );

  // ==========================================================
  // Checking
  task automatic check(string nm, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Each finished transfer is compared with the oldest note
  always @(posedge core_clk) begin
    exp_t x;
    if (psel && penable && pready) begin
      x = expq.pop_front();
      check("pslverr", {31'h0, x.err}, {31'h0, pslverr});
      check("prdata", x.data, prdata & x.mask);
    end
  end
  // Open-switch stretch is conversion plus gap; -1 marks an abort
  always @(posedge core_clk) begin
    if (!afe.powered)
      seen <= 0;
    else if (afe.hold_connect) begin
      if (seen && cnt > 0) begin
        if (spanq[0] >= 0)
          check("span", spanq[0], cnt);
        void'(spanq.pop_front());
      end
      seen <= 1;
      cnt <= 0;
    end else if (seen)
      cnt <= cnt + 1;
  end

  // ==========================================================
  // APB master
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d, exp_t x,
                     output logic [31:0] r);
    int n = 0;
    expq.push_back(x);
    @(posedge core_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    do begin
      @(posedge core_clk);
      n++;
    end while (!pready && n < 20);
    r = prdata;
    if (!pready)
      check("pready", 1, 0);
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d, logic err = 0);
    logic [31:0] r;
    apb(1, a, {24'h0, d}, {err, 64'h0}, r);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e,
                    logic [31:0] m = 32'hFFFFFFFF, logic err = 0);
    logic [31:0] r;
    apb(0, a, 0, {err, m, e}, r);
  endtask
  task automatic wait_hold();
    int n = 0;
    while (!afe.hold_connect && n < 400) begin
      @(posedge core_clk);
      n++;
    end
    check("hold_connect", 1, afe.hold_connect);
  endtask
  task automatic res_chk(logic j);
    if (j) begin
      rd(OFS_RES_HI, {30'h0, res_a[9:8]});
      rd(OFS_RES_LO, {24'h0, res_a[7:0]});
    end else begin
      rd(OFS_RES_HI, {24'h0, res_a[9:2]});
      rd(OFS_RES_LO, {24'h0, res_a[1:0], 6'h0});
    end
  endtask
  function automatic int ncyc(logic [2:0] s);
    case (s)
      3'h0: return 2;
      3'h4: return 4;
      3'h1: return 8;
      3'h5: return 16;
      3'h2: return 32;
      3'h6: return 64;
      default: return int'(RC_TAD_CYC);
    endcase
  endfunction

  // ==========================================================
  // One conversion, read back in both alignments
  task automatic convert(logic [2:0] s, logic [2:0] ch, logic j,
                         logic [3:0] cfg, logic irq);
    int n;
    logic [31:0] r;
    lvl[ch] <= 10'($random(seed));
    wr(OFS_CTRL1, {j, s[2], 2'b00, cfg});
    wr(OFS_CTRL0, {s[1:0], ch, 3'b001});
    wr(OFS_STATUS, {6'h0, irq, 1'b1});
    wait_hold();
    repeat (ACQ_WAIT_CYC) @(posedge core_clk);
    res_a = lvl[ch];
    spanq.push_back(14 * ncyc(s));
    wr(OFS_CTRL0, {s[1:0], ch, 3'b101});
    // Move the pin after the switch opened; result must not follow
    repeat (2) @(posedge core_clk);
    lvl[ch] <= ~res_a;
    n = 0;
    do begin
      apb(0, OFS_CTRL0, 0, 65'h0, r);
      n++;
    end while (r[2] && n < 2000);
    check("go", 0, r[2]);
    repeat (2) @(posedge core_clk);
    check("conv_irq", irq, conv_irq);
    rd(OFS_STATUS, {30'h0, irq, 1'b1}, 32'h3);
    res_chk(j);
    wr(OFS_CTRL1, {!j, s[2], 2'b00, cfg});
    res_chk(!j);
    wr(OFS_STATUS, {6'h0, irq, 1'b1});
    rd(OFS_STATUS, 0, 32'h1);
    wait_hold();
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge core_clk);
    rst <= 0;
    port_pins <= 8'($random(seed));
    rd(OFS_CTRL0, 0);
    rd(OFS_CTRL1, 0);
    rd(OFS_PORT, 0);
    wr(OFS_PORT, 8'hFF, 1);
    rd(8'h18, 0, 32'hFFFFFFFF, 1);
    // Every select is swept; the ideal comparator settles at once, so
    // periods under the 1.6 us floor still convert exactly here
    for (int s = 0; s < 8; s++)
      convert(3'(s), 3'(s), s[0], s[0] ? 4'hE : 4'h0, s[1]);
    rd(OFS_PORT, {24'h0, port_pins & 8'hFE});
    // Abort keeps the old result and no done flag
    wr(OFS_CTRL0, 8'h01);
    repeat (ACQ_WAIT_CYC) @(posedge core_clk);
    spanq.push_back(-1);
    wr(OFS_CTRL0, 8'h05);
    repeat (5) @(posedge core_clk);
    wr(OFS_CTRL0, 8'h01);
    wait_hold();
    rd(OFS_STATUS, 0, 32'h1);
    res_chk(1'b0);
    // Reset in mid-conversion; result pair survives
    repeat (ACQ_WAIT_CYC) @(posedge core_clk);
    wr(OFS_CTRL0, 8'h05);
    repeat (5) @(posedge core_clk);
    rst <= 1;
    @(posedge core_clk);
    check("afe", 0, afe);
    rst <= 0;
    rd(OFS_CTRL0, 0);
    rd(OFS_STATUS, 0, 32'hC);
    res_chk(1'b0);
    // Software writes land in the left-justified view
    res_a = 10'h295;
    wr(OFS_RES_HI, 8'hA5);
    wr(OFS_RES_LO, 8'h40);
    res_chk(1'b0);
    final_report();
  end
  // Watchdog, far beyond the expected few thousand cycles
  initial begin
    #(60000 * 50);
    error_cnt++;
    final_report();
  end
endmodule // tb_top
